//--- hdl/aofcm_device.sv
// converter side: sample timing, range check, pipeline and output format
`timescale 1ns/1ps
`include "aofcm_regs.svh"
module aofcm_device #(
  parameter int PIPE_DEPTH = `AOFCM_PIPE_DEPTH,
  parameter int CNT_W = `AOFCM_CNT_W
) (
  input wire logic CLK,
  input wire logic RST,
  aofcm_link_if.device LINK,
  input wire logic signed [15:0] ANALOG_IN_POS,
  input wire logic signed [15:0] ANALOG_IN_NEG,
  output logic HOLD_PHASE,
  output logic SAMPLE_TAKEN
);
  localparam logic signed [16:0] SPAN = `AOFCM_HALF_SPAN;
  localparam logic signed [16:0] ONE = 17'sh00001;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  // pin levels of an idle host: pos low, neg high, enable off
  localparam logic [5:0] PIN_IDLE = `AOFCM_PIN_IDLE;

  // pin levels: pos, neg, grounded, format, stabilizer, oe_low
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic clk_pos_s;
  logic clk_neg_s;
  logic neg_gnd_s;
  logic fmt_s;
  logic dcs_s;
  logic oe_low_s;

  // hold phase seen at the pins and the edge detector on it
  logic hold_ext;
  logic hold_ext_q;
  logic sample_edge;

  // stabilizer state: measured period and regenerated phase
  logic [CNT_W-1:0] phase_cnt;
  logic [CNT_W-1:0] period;
  logic hold_dcs;

  // conversion of the held input
  logic signed [16:0] diff;
  logic below;
  logic above;
  logic [13:0] next_code;
  logic next_otr;

  // pipeline stages, each holds the flag above the code
  logic [14:0] pipe [PIPE_DEPTH];

  // two flops on every pin input, only the second flop reads the first one;
  // both reset to the idle levels so no false edge or enable follows
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_meta <= PIN_IDLE;
    end else begin
      pin_meta <= {LINK.clk_pos, LINK.clk_neg, LINK.neg_grounded,
                   LINK.format_select_pin, LINK.duty_stabilizer_select,
                   LINK.output_enable_low};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_sync <= PIN_IDLE;
    end else begin
      pin_sync <= pin_meta;
    end
  end

  assign clk_pos_s = pin_sync[5];
  assign clk_neg_s = pin_sync[4];
  assign neg_gnd_s = pin_sync[3];
  assign fmt_s = pin_sync[2];
  assign dcs_s = pin_sync[1];
  assign oe_low_s = pin_sync[0];

  // clock receiver: single pin when neg is grounded, else compare
  always_comb begin
    if (neg_gnd_s) begin
      hold_ext = clk_pos_s;
    end else begin
      hold_ext = clk_pos_s & ~clk_neg_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_ext_q <= 1'b0;
    end else begin
      hold_ext_q <= hold_ext;
    end
  end

  // only the rising edge samples; it is the low-jitter edge
  assign sample_edge = hold_ext & ~hold_ext_q;

  // phase counter restarts on each sampling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_cnt <= '0;
    end else if (sample_edge) begin
      phase_cnt <= CNT_ONE;
    end else if (phase_cnt != '1) begin
      phase_cnt <= phase_cnt + CNT_ONE;
    end
  end

  // period learned from edge to edge, so a rate change
  // takes one period to settle in the regenerated phase
  always_ff @(posedge CLK) begin
    if (RST) begin
      period <= '0;
    end else if (sample_edge) begin
      period <= phase_cnt;
    end
  end

  // regenerated falling edge at half the learned period; the edge
  // cycle itself is the first hold cycle, so the clear comes one
  // count early to keep both halves equal
  always_ff @(posedge CLK) begin
    if (RST) begin
      hold_dcs <= 1'b0;
    end else if (sample_edge) begin
      hold_dcs <= 1'b1;
    end else if ((phase_cnt + CNT_ONE) >= (period >> 1)) begin
      hold_dcs <= 1'b0;
    end
  end

  // stabilizer pin picks regenerated or pin-level phase
  always_comb begin
    if (dcs_s) begin
      HOLD_PHASE = hold_dcs | sample_edge;
    end else begin
      HOLD_PHASE = hold_ext;
    end
  end

  assign SAMPLE_TAKEN = sample_edge;

  // difference of the two inputs in one extra bit
  assign diff = 17'(ANALOG_IN_POS) - 17'(ANALOG_IN_NEG);
  assign below = diff < -SPAN;
  assign above = diff > (SPAN - ONE);

  // binary code with saturation at both ends
  always_comb begin
    if (below) begin
      next_code = `AOFCM_CODE_MIN;
    end else if (above) begin
      next_code = `AOFCM_CODE_MAX;
    end else begin
      next_code = 14'(diff + SPAN);
    end
    next_otr = below | above;
  end

  // every stage shifts on the sampling edge, flag beside its code
  generate
    for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_pipe
      if (i == 0) begin : g_head
        // first stage takes the fresh conversion
        always_ff @(posedge CLK) begin
          if (RST) begin
            pipe[i] <= 15'h0000;
          end else if (sample_edge) begin
            pipe[i] <= {next_otr, next_code};
          end
        end
      end else begin : g_tail
        // later stages pass the pair on; no stage below zero exists
        always_ff @(posedge CLK) begin
          if (RST) begin
            pipe[i] <= 15'h0000;
          end else if (sample_edge) begin
            pipe[i] <= pipe[i-1];
          end
        end
      end
    end
  endgenerate

  // one register loads code and flag together on the same edge;
  // the flag stays set until an in-range sample reaches the end
  always_ff @(posedge CLK) begin
    if (RST) begin
      LINK.data_o <= 14'h0000;
      LINK.out_of_range_flag <= 1'b0;
    end else if (sample_edge) begin
      LINK.out_of_range_flag <= pipe[PIPE_DEPTH-1][14];
      if (fmt_s) begin
        LINK.data_o <= {~pipe[PIPE_DEPTH-1][13],
                        pipe[PIPE_DEPTH-1][12:0]};
      end else begin
        LINK.data_o <= pipe[PIPE_DEPTH-1][13:0];
      end
    end
  end

  // drivers follow the synchronised enable, high floats the bus
  always_ff @(posedge CLK) begin
    if (RST) begin
      LINK.data_oe <= 1'b0;
    end else begin
      LINK.data_oe <= ~oe_low_s;
    end
  end
endmodule : aofcm_device

//--- hdl/aofcm_regs.svh
// constants for the sample converter formatter and its capture controller
`ifndef AOFCM_REGS_SVH
`define AOFCM_REGS_SVH
`define AOFCM_CODE_W 14
`define AOFCM_IN_W 16
`define AOFCM_HALF_SPAN 17'h02000
`define AOFCM_CODE_MAX 14'h3FFF
`define AOFCM_CODE_MIN 14'h0000
`define AOFCM_PIPE_DEPTH 8
`define AOFCM_SETTLE_CYC 16'h0065
`define AOFCM_CNT_W 16
`define AOFCM_DIV_RST 16'h0008
`define AOFCM_DIV_MIN 16'h0004
`define AOFCM_REG_CTRL 12'h000
`define AOFCM_REG_STAT 12'h004
`define AOFCM_REG_MASK 12'h008
`define AOFCM_REG_SAMPLE 12'h00C
`define AOFCM_REG_DIV 12'h010
`define AOFCM_CTRL_RUN 0
`define AOFCM_CTRL_FMT 1
`define AOFCM_CTRL_DCS 2
`define AOFCM_CTRL_OE 3
`define AOFCM_CTRL_SE 4
`define AOFCM_CTRL_W 5
`define AOFCM_STAT_SAMPLE 0
`define AOFCM_STAT_UNDER 1
`define AOFCM_STAT_OVER 2
`define AOFCM_STAT_W 3
`define AOFCM_SMP_OTR 14
`define AOFCM_SMP_CLASS_LO 16
`define AOFCM_SMP_SETTLED 18
`define AOFCM_PIN_IDLE 6'h11
`endif

//--- hdl/aofcm_pkg.sv
// shared types for the sample converter formatter and capture controller
package aofcm_pkg;
  typedef logic [13:0] aofcm_code_t;
  typedef enum logic [1:0] {
    AOFCM_IN_RANGE = 2'h0,
    AOFCM_UNDER = 2'h1,
    AOFCM_OVER = 2'h2
  } aofcm_class_e;
  typedef enum logic [2:0] {
    AOFCM_IDLE = 3'h1,
    AOFCM_HIGH = 3'h2,
    AOFCM_LOW = 3'h4
  } aofcm_clk_state_e;
endpackage : aofcm_pkg

//--- hdl/aofcm_link_if.sv
// link between the converter formatter and the capture controller
`timescale 1ns/1ps
interface aofcm_link_if;
  logic clk_pos;
  logic clk_neg;
  logic neg_grounded;
  logic format_select_pin;
  logic duty_stabilizer_select;
  logic output_enable_low;
  logic [13:0] data_o;
  logic data_oe;
  logic out_of_range_flag;
  wire [13:0] data_bus;
  // released bus reads as the inverse word, so a capture taken
  // while the drivers are off shows up as a wrong code
  assign data_bus = data_oe ? data_o : ~data_o;
  modport device (
    input clk_pos, clk_neg, neg_grounded, format_select_pin,
    input duty_stabilizer_select, output_enable_low,
    output data_o, data_oe, out_of_range_flag
  );
  modport host (
    output clk_pos, clk_neg, neg_grounded, format_select_pin,
    output duty_stabilizer_select, output_enable_low,
    input data_bus, out_of_range_flag
  );
endinterface : aofcm_link_if

//--- hdl/aofcm_host.sv
// capture side: sample clock, straps, capture and APB register file
`timescale 1ns/1ps
`include "aofcm_regs.svh"
module aofcm_host (
  input wire logic CLK,
  input wire logic RST,
  aofcm_link_if.host LINK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic SAMPLE_VALID,
  output logic [13:0] SAMPLE_CODE,
  output logic [1:0] SAMPLE_CLASS
);
  logic [4:0] ctrl;
  logic [15:0] div;
  logic [2:0] stat;
  logic [2:0] mask;
  logic [15:0] settle;
  logic [15:0] cnt;
  logic [2:0] next_stat;
  logic wr;
  logic mapped;
  logic capture;
  logic settled;
  logic msb_bin;
  aofcm_pkg::aofcm_class_e cls;
  aofcm_pkg::aofcm_clk_state_e st;

  assign wr = PSEL & PENABLE & PWRITE;
  assign mapped = PADDR == `AOFCM_REG_CTRL || PADDR == `AOFCM_REG_STAT ||
                  PADDR == `AOFCM_REG_MASK || PADDR == `AOFCM_REG_SAMPLE ||
                  PADDR == `AOFCM_REG_DIV;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // control and divider; divider floors at the link's safe minimum
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= 5'h00;
      div <= `AOFCM_DIV_RST;
      mask <= 3'h0;
    end else if (wr) begin
      if (PADDR == `AOFCM_REG_CTRL) ctrl <= PWDATA[4:0];
      if (PADDR == `AOFCM_REG_MASK) mask <= PWDATA[2:0];
      if (PADDR == `AOFCM_REG_DIV) begin
        div <= (PWDATA[15:0] < `AOFCM_DIV_MIN) ? `AOFCM_DIV_MIN : PWDATA[15:0];
      end
    end
  end

  // straps; output enable only moves on software writes
  assign LINK.format_select_pin = ctrl[`AOFCM_CTRL_FMT];
  assign LINK.duty_stabilizer_select = ctrl[`AOFCM_CTRL_DCS];
  assign LINK.output_enable_low = ~ctrl[`AOFCM_CTRL_OE];
  assign LINK.neg_grounded = ctrl[`AOFCM_CTRL_SE];
  assign LINK.clk_neg = ~ctrl[`AOFCM_CTRL_SE] & (st != aofcm_pkg::AOFCM_HIGH);
  assign LINK.clk_pos = st == aofcm_pkg::AOFCM_HIGH;

  // sample clock generator, div cycles per half period
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= aofcm_pkg::AOFCM_IDLE;
      cnt <= 16'h0000;
    end else begin
      case (st)
        aofcm_pkg::AOFCM_IDLE: begin
          cnt <= 16'h0001;
          if (ctrl[`AOFCM_CTRL_RUN]) st <= aofcm_pkg::AOFCM_HIGH;
        end
        aofcm_pkg::AOFCM_HIGH: begin
          cnt <= (cnt >= div) ? 16'h0001 : cnt + 16'h0001;
          if (cnt >= div) st <= aofcm_pkg::AOFCM_LOW;
        end
        aofcm_pkg::AOFCM_LOW: begin
          cnt <= (cnt >= div) ? 16'h0001 : cnt + 16'h0001;
          if (cnt >= div) begin
            st <= ctrl[`AOFCM_CTRL_RUN] ? aofcm_pkg::AOFCM_HIGH : aofcm_pkg::AOFCM_IDLE;
          end
        end
        default: st <= aofcm_pkg::AOFCM_IDLE;
      endcase
    end
  end

  // capture mid-period, after the device has updated its word
  assign capture = st == aofcm_pkg::AOFCM_HIGH && cnt >= div;

  // settling count restarts on any divider write or stabilizer change, not on a single-ended change
  always_ff @(posedge CLK) begin
    if (RST || ~ctrl[`AOFCM_CTRL_RUN] ||
        (wr && (PADDR == `AOFCM_REG_DIV ||
                (PADDR == `AOFCM_REG_CTRL && PWDATA[2] != ctrl[2])))) begin
      settle <= 16'h0000;
    end else if (capture && !settled) begin
      settle <= settle + 16'h0001;
    end
  end
  assign settled = settle >= `AOFCM_SETTLE_CYC;

  // flag plus binary top bit tell under from over
  assign msb_bin = ctrl[`AOFCM_CTRL_FMT] ^ LINK.data_bus[13];
  always_comb begin
    if (!LINK.out_of_range_flag) cls = aofcm_pkg::AOFCM_IN_RANGE;
    else if (msb_bin) cls = aofcm_pkg::AOFCM_OVER;
    else cls = aofcm_pkg::AOFCM_UNDER;
  end

  // flag already aligned with its word, so act on the same capture
  always_ff @(posedge CLK) begin
    if (RST) begin
      SAMPLE_VALID <= 1'b0;
      SAMPLE_CODE <= 14'h0000;
      SAMPLE_CLASS <= 2'h0;
    end else begin
      SAMPLE_VALID <= capture & settled & ctrl[`AOFCM_CTRL_OE];
      if (capture && ctrl[`AOFCM_CTRL_OE]) begin
        SAMPLE_CODE <= LINK.data_bus;
        SAMPLE_CLASS <= cls;
      end
    end
  end

  // sticky events, write one clears, a new event wins
  always_comb begin
    next_stat = stat;
    if (wr && PADDR == `AOFCM_REG_STAT) next_stat = stat & ~PWDATA[2:0];
    if (SAMPLE_VALID) begin
      next_stat[`AOFCM_STAT_SAMPLE] = 1'b1;
      if (SAMPLE_CLASS == aofcm_pkg::AOFCM_UNDER) next_stat[`AOFCM_STAT_UNDER] = 1'b1;
      if (SAMPLE_CLASS == aofcm_pkg::AOFCM_OVER) next_stat[`AOFCM_STAT_OVER] = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) stat <= 3'h0;
    else stat <= next_stat;
  end
  assign IRQ = |(stat & mask);

  // read data captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      case (PADDR)
        `AOFCM_REG_CTRL: PRDATA <= {27'h0000000, ctrl};
        `AOFCM_REG_STAT: PRDATA <= {29'h00000000, stat};
        `AOFCM_REG_MASK: PRDATA <= {29'h00000000, mask};
        `AOFCM_REG_SAMPLE: PRDATA <= {13'h0000, settled, SAMPLE_CLASS, 1'h0,
                                      |SAMPLE_CLASS, SAMPLE_CODE};
        `AOFCM_REG_DIV: PRDATA <= {16'h0000, div};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end
endmodule : aofcm_host

//--- bench/aofcm_link_properties.sv
// link checker for the formatter and capture controller
`timescale 1ns/1ps
module aofcm_link_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic clk_pos,
  input wire logic clk_neg,
  input wire logic neg_grounded,
  input wire logic output_enable_low,
  input wire logic [13:0] data_o,
  input wire logic data_oe,
  input wire logic out_of_range_flag
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  // enable pin reaches the drivers within the sync delay
  a_oe_drive: assert property ($fell(output_enable_low) ##1 (!output_enable_low)[*4]
    |-> data_oe)
    else $error("data drivers not enabled");
  a_oe_float: assert property ($rose(output_enable_low) ##1 output_enable_low[*4]
    |-> !data_oe)
    else $error("data drivers not released");
  // clock pair polarity per mode
  a_neg_diff: assert property (!neg_grounded |-> clk_neg == !clk_pos)
    else $error("neg clock not complement");
  a_neg_ground: assert property (neg_grounded |-> !clk_neg)
    else $error("neg clock not grounded");
  // an overload word is a rail code in either format
  a_flag_code: assert property (out_of_range_flag |->
    data_o[12:0] == 13'h0000 || data_o[12:0] == 13'h1FFF)
    else $error("flagged word not saturated");
  // updates only follow a rising sample clock
  a_word_edge: assert property ($changed(data_o) |->
    $past(clk_pos, 2) && $past(clk_pos, 3))
    else $error("word changed off the sampling edge");
  a_flag_edge: assert property ($changed(out_of_range_flag) |->
    $past(clk_pos, 2) && $past(clk_pos, 3))
    else $error("flag changed off the sampling edge");
  // one update per period: shortest period is eight cycles
  a_word_hold: assert property ($changed(data_o) || $changed(out_of_range_flag) |=>
    ($stable(data_o) && $stable(out_of_range_flag))[*7])
    else $error("word or flag updated twice in a period");
endmodule : aofcm_link_properties

//--- bench/tb_top.sv
// self-checking bench: host and device joined over the link
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic [15:0] ANALOG_IN_POS = 16'h0000;
  logic [15:0] ANALOG_IN_NEG = 16'h0000;
  wire [31:0] PRDATA;
  wire PREADY;
  wire PSLVERR;
  wire IRQ;
  wire SAMPLE_VALID;
  wire [13:0] SAMPLE_CODE;
  wire [1:0] SAMPLE_CLASS;
  wire HOLD_PHASE;
  wire SAMPLE_TAKEN;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic slv_err;
  int vals[6] = '{-9000, -8192, 0, 8191, 9000, 5};

  always #5 CLK = ~CLK;

  aofcm_link_if link ();
  aofcm_device aofcm_device_i (.CLK(CLK), .RST(RST), .LINK(link),
    .ANALOG_IN_POS(ANALOG_IN_POS), .ANALOG_IN_NEG(ANALOG_IN_NEG),
    .HOLD_PHASE(HOLD_PHASE), .SAMPLE_TAKEN(SAMPLE_TAKEN));
  aofcm_host aofcm_host_i (.CLK(CLK), .RST(RST), .LINK(link), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_CODE(SAMPLE_CODE), .SAMPLE_CLASS(SAMPLE_CLASS));
  aofcm_link_properties aofcm_link_properties_i (.CLK(CLK), .RST(RST),
    .clk_pos(link.clk_pos), .clk_neg(link.clk_neg), .neg_grounded(link.neg_grounded),
    .output_enable_low(link.output_enable_low), .data_o(link.data_o),
    .data_oe(link.data_oe), .out_of_range_flag(link.out_of_range_flag));

  task automatic conclude();
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (k >= 50) err_total++;
    rd = PRDATA;
    slv_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // bounded wait for n captured samples
  task automatic wait_valid(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge CLK);
        k++;
      end while (SAMPLE_VALID !== 1'b1 && k < 3000);
      if (k >= 3000) err_total++;
    end
  endtask : wait_valid

  // one sample period: its length and the cycles spent in hold
  task automatic chk_phase();
    int hi;
    int per;
    hi = 0;
    per = 0;
    do begin
      @(posedge CLK);
      per++;
    end while (SAMPLE_TAKEN !== 1'b1 && per < 100);
    hi = 0;
    per = 0;
    do begin
      if (HOLD_PHASE === 1'b1) hi++;
      @(posedge CLK);
      per++;
    end while (SAMPLE_TAKEN !== 1'b1 && per < 100);
    chk("sample period", per, 32'h8);
    chk("hold cycles", hi, 32'h4);
  endtask : chk_phase

  // apply a steady difference, let it clear the pipeline, check word and class
  task automatic conv(input int v, input logic fmt);
    int b;
    logic [13:0] code;
    logic [1:0] cls;
    b = v + 8192;
    b = (b < 0) ? 0 : (b > 16383) ? 16383 : b;
    cls = (v < -8192) ? 2'h1 : (v > 8191) ? 2'h2 : 2'h0;
    code = 14'(b) ^ {fmt, 13'h0000};
    ANALOG_IN_POS <= 16'(v + 100);
    ANALOG_IN_NEG <= 16'h0064;
    wait_valid(11);
    chk("pin word", {18'h0, SAMPLE_CODE}, {18'h0, code});
    chk("class", {30'h0, SAMPLE_CLASS}, {30'h0, cls});
    apb(1'b0, 12'h00C, 32'h0);
    chk("sample reg", rd, {13'h0, 1'b1, cls, 1'b0, cls != 2'h0, code});
  endtask : conv

  // watchdog sized well past the full sequence
  initial begin
    repeat (30000) @(posedge CLK);
    err_total++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("div reset", rd, 32'h8);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped err", {31'h0, slv_err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h010, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    chk("div floor", rd, 32'h4);
    // pass 0: differential clock, binary; pass 1: single-ended, stabilizer, twos
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 12'h000, {27'h0, f[0], 1'b1, f[0], f[0], 1'b1});
      wait_valid(1);
      chk_phase();
      foreach (vals[i]) conv(vals[i], f[0]);
    end
    // overload event from a clean status: masked, then raised, then cleared
    apb(1'b1, 12'h004, 32'h7);
    conv(9000, 1'b1);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b0, 12'h004, 32'h0);
    chk("over status", {31'h0, rd[2]}, 32'h1);
    chk("irq raised", {31'h0, IRQ}, 32'h1);
    conv(5, 1'b1);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b0, 12'h004, 32'h0);
    chk("over cleared", {31'h0, rd[2]}, 32'h0);
    chk("irq cleared", {31'h0, IRQ}, 32'h0);
    chk("drivers on", {31'h0, link.data_oe}, 32'h1);
    // drivers off: enable must drop within eight cycles of the write
    apb(1'b1, 12'h000, 32'h13);
    repeat (8) @(posedge CLK);
    chk("drivers off", {31'h0, link.data_oe}, 32'h0);
    conclude();
  end
endmodule : tb_top
